// ===== endpoint_control_pkg.sv
// package: endpoint control map, field positions, codes and reset values
// Overview of operation
// R01: tx iso set: every sent packet counts good, number goes to completion fifo
// R02: tx iso clear: sent packet held until host ack arrives
// R03: good transmitted packet leaves the tx queue and its buffer is freed
// R04: rx iso set: no handshake for out or setup
// R05: address match starts page allocation and a new packet record
// R06: firmware checks pid and crc valid and dequeues bad packets
// R07: tx control 00 disabled silent, 01 stall on in
// R08: tx control 10 data or nak by queue, 11 always nak; code sends no nak while tx iso is set
// R09: rx control 00 disabled silent, 01 stall on out
// R10: rx control 10 ack or nak by receive ready, 11 always nak
// R11: tx toggle inverts after each successful transmission
// R12: firmware changes tx toggle only while endpoint disabled; code accepts tx toggle writes at any time
// R13: read-only rx toggle at bit 0 shows last data0 or data1
// R14: sixteen registers 0x7f80..0x7f8f indexed by token endpoint number
// R15: firmware stalls in two steps: clear high bit, then set low bit
// R16: unexpected toggle flagged when toggle equals previous toggle
// R17: all control registers reset to zero
package endpoint_control_pkg;
  localparam logic [15:0] ENDPOINT_CONTROL_BASE  = 16'h7f80;
  localparam logic [15:0] ENDPOINT_CONTROL_LAST  = 16'h7f8f;
  localparam int          NUM_EP        = 16;
  localparam int          TX_ISO_BIT    = 7;
  localparam int          RX_ISO_BIT    = 6;
  localparam int          TX_HI_BIT     = 5;
  localparam int          RX_HI_BIT     = 4;
  localparam int          TX_LO_BIT     = 3;
  localparam int          RX_LO_BIT     = 2;
  localparam int          TX_TOG_BIT    = 1;
  localparam int          RX_TOG_BIT    = 0;
  localparam logic [7:0]  ENDPOINT_CONTROL_RESET = 8'h00;
  localparam logic [7:0]  EP_WR_MASK    = 8'hfe;
  localparam logic [1:0]  CONT_OFF      = 2'h0;
  localparam logic [1:0]  CONT_STALL    = 2'h1;
  localparam logic [1:0]  CONT_NORMAL   = 2'h2;
  localparam logic [1:0]  CONT_NAK      = 2'h3;
  // handshake answer codes
  localparam logic [1:0]  HS_NONE       = 2'h0;
  localparam logic [1:0]  HS_ACK        = 2'h1;
  localparam logic [1:0]  HS_NAK        = 2'h2;
  localparam logic [1:0]  HS_STALL      = 2'h3;
  typedef enum logic [1:0] {
    TOK_OUT,
    TOK_IN,
    TOK_SETUP
  } token_e;
endpackage : endpoint_control_pkg

// ===== rx_response.sv
// module: receive side handshake decision and toggle check
`timescale 1ns/1ps
module rx_response
  import endpoint_control_pkg::*;
(
  input  wire logic       iso,
  input  wire logic [1:0] cont,
  input  wire logic       rx_ready,
  input  wire logic       pkt_toggle,
  input  wire logic       last_toggle,
  output logic [1:0]      hs,
  output logic            bad_toggle
);
  // out/setup answer from rx control
  always_comb begin
    case (cont)
      CONT_STALL:  hs = HS_STALL;                      // R09
      CONT_NORMAL: hs = rx_ready ? HS_ACK : HS_NAK;    // R10
      CONT_NAK:    hs = HS_NAK;                        // R10
      default:     hs = HS_NONE;                       // R09
    endcase
    if (iso) begin
      hs = HS_NONE;                                    // R04
    end
  end

  // same toggle twice in a row
  assign bad_toggle = (pkt_toggle == last_toggle);     // R16
endmodule : rx_response

// ===== tx_response.sv
// module: transmit side in-token answer decision
`timescale 1ns/1ps
module tx_response
  import endpoint_control_pkg::*;
(
  input  wire logic       iso,
  input  wire logic [1:0] cont,
  input  wire logic       queue_has_data,
  output logic            send_data,
  output logic [1:0]      hs
);
  // in answer from tx control
  always_comb begin
    send_data = 1'b0;
    hs        = HS_NONE;
    case (cont)
      CONT_STALL: hs = HS_STALL;                       // R07
      CONT_NORMAL: begin
        send_data = queue_has_data;                    // R08
        hs        = queue_has_data ? HS_NONE : HS_NAK; // R08
      end
      CONT_NAK: hs = HS_NAK;                           // R08
      default:  hs = HS_NONE;                          // R07
    endcase
    if (iso && hs == HS_NAK) begin
      hs = HS_NONE;
    end
  end
endmodule : tx_response

// ===== usb_endpoint_handshake_control.sv
// module: per-endpoint control registers and token response sequencing
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module usb_endpoint_handshake_control
  import endpoint_control_pkg::*;
#(
  parameter int EP_COUNT = NUM_EP
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // decoded token from the serial engine
  input  wire logic        token_valid,
  input  wire logic [1:0]  token_kind,
  input  wire logic [3:0]  token_ep,
  input  wire logic        addr_match,
  // packet end events
  input  wire logic        rx_done,
  input  wire logic        rx_data_toggle,
  input  wire logic        rx_ready,
  input  wire logic        tx_done,
  input  wire logic        host_ack,
  input  wire logic        tx_queue_has_data,
  input  wire logic [3:0]  tx_packet_num,
  // answers
  output logic [1:0]       handshake,
  output logic             handshake_valid,
  output logic             send_data,
  output logic             tx_data_toggle,
  output logic             page_alloc_start,
  output logic             unexpected_toggle_flag,
  output logic             completion_push,
  output logic [3:0]       completion_num,
  output logic             tx_dequeue
);
  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_s1;
  logic rst_s2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  logic rst_i_n;
  assign rst_i_n = rst_s2;

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TX_WAIT,
    ST_RX_WAIT
  } seq_e;
  seq_e        state;
  logic [7:0]  ep_reg [EP_COUNT];
  logic [3:0]  cur_ep;
  logic [3:0]  cur_pkt;
  logic [7:0]  sel;
  logic [3:0]  wr_idx;
  logic        wr_hit;
  logic        rd_hit;
  logic        tx_good;
  logic        rx_take;
  logic [1:0]  tx_hs;
  logic [1:0]  rx_hs;
  logic        tx_send;
  logic        rx_bad;
  logic [7:0]  tok_reg;

  assign wr_idx = reg_addr[3:0];
  assign wr_hit = reg_wr && reg_addr >= ENDPOINT_CONTROL_BASE
                  && reg_addr <= ENDPOINT_CONTROL_LAST;         // R14
  assign rd_hit = reg_rd && reg_addr >= ENDPOINT_CONTROL_BASE
                  && reg_addr <= ENDPOINT_CONTROL_LAST;
  assign sel     = ep_reg[cur_ep];
  assign tok_reg = ep_reg[token_ep];                   // R14
  // successful transmission: iso always, else after ack
  assign tx_good = state == ST_TX_WAIT && tx_done
                   && (sel[TX_ISO_BIT] || host_ack);   // R01 R02
  assign rx_take = state == ST_RX_WAIT && rx_done;

  ////////////////////////////////////////////////////////////////////////
  // answer decoders
  tx_response u_tx (
    .iso            (tok_reg[TX_ISO_BIT]),
    .cont           ({tok_reg[TX_HI_BIT], tok_reg[TX_LO_BIT]}),
    .queue_has_data (tx_queue_has_data),
    .send_data      (tx_send),
    .hs             (tx_hs)
  );

  rx_response u_rx (
    .iso         (sel[RX_ISO_BIT]),
    .cont        ({sel[RX_HI_BIT], sel[RX_LO_BIT]}),
    .rx_ready    (rx_ready),
    .pkt_toggle  (rx_data_toggle),
    .last_toggle (sel[RX_TOG_BIT]),
    .hs          (rx_hs),
    .bad_toggle  (rx_bad)
  );

  ////////////////////////////////////////////////////////////////////////
  // control registers: firmware write, toggle updates
  genvar g;
  generate
    for (g = 0; g < EP_COUNT; g++) begin : g_ep
      always_ff @(posedge clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
          ep_reg[g] <= ENDPOINT_CONTROL_RESET;                  // R17
        end else begin
          if (wr_hit && wr_idx == 4'(g)) begin
            ep_reg[g][7:1] <= reg_wdata[7:1];          // R12
          end
          if (tx_good && cur_ep == 4'(g)) begin
            ep_reg[g][TX_TOG_BIT] <= ~ep_reg[g][TX_TOG_BIT]; // R11
          end
          if (rx_take && cur_ep == 4'(g)) begin
            ep_reg[g][RX_TOG_BIT] <= rx_data_toggle;   // R13
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after strobe
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      reg_rdata <= 8'h00;
    end else if (rd_hit) begin
      reg_rdata <= ep_reg[wr_idx];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transaction sequencer
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      state   <= ST_IDLE;
      cur_ep  <= 4'h0;
      cur_pkt <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (token_valid && addr_match) begin
            cur_ep  <= token_ep;                       // R14
            cur_pkt <= tx_packet_num;
            if (token_kind == 2'(TOK_IN)) begin
              if (tx_send) begin
                state <= ST_TX_WAIT;
              end
            end else begin
              state <= ST_RX_WAIT;
            end
          end
        end
        ST_TX_WAIT: begin
          if (tx_done) begin
            state <= ST_IDLE;
          end
        end
        ST_RX_WAIT: begin
          if (rx_done) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs: handshakes, record start, completion
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      handshake              <= HS_NONE;
      handshake_valid        <= 1'b0;
      send_data              <= 1'b0;
      page_alloc_start       <= 1'b0;
      unexpected_toggle_flag <= 1'b0;
      completion_push        <= 1'b0;
      completion_num         <= 4'h0;
      tx_dequeue             <= 1'b0;
    end else begin
      handshake_valid  <= 1'b0;
      handshake        <= HS_NONE;
      send_data        <= 1'b0;
      page_alloc_start <= 1'b0;
      completion_push  <= tx_good;                     // R01
      tx_dequeue       <= tx_good;                     // R03
      if (tx_good) begin
        completion_num <= cur_pkt;
      end
      if (state == ST_IDLE && token_valid && addr_match) begin
        if (token_kind == 2'(TOK_IN)) begin
          send_data       <= tx_send;
          handshake       <= tx_hs;
          handshake_valid <= tx_hs != HS_NONE;
        end else begin
          page_alloc_start <= 1'b1;                    // R05
        end
      end
      if (rx_take) begin
        handshake              <= rx_hs;               // R04
        handshake_valid        <= rx_hs != HS_NONE;
        unexpected_toggle_flag <= rx_bad;              // R16
      end
    end
  end

  assign tx_data_toggle = sel[TX_TOG_BIT];

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_NO_HS_ISO_RX: assert property (@(posedge clk) disable iff (!rst_i_n)
    rx_take && sel[RX_ISO_BIT] |=> !handshake_valid) // R04
    else $error("handshake sent on iso receive");
  AST_TOGGLE_FLIP: assert property (@(posedge clk) disable iff (!rst_i_n)
    tx_good |=> tx_data_toggle != $past(sel[TX_TOG_BIT])) // R11
    else $error("tx toggle did not invert");
  AST_NOACK_HOLD: assert property (@(posedge clk) disable iff (!rst_i_n)
    state == ST_TX_WAIT && tx_done && !host_ack && !sel[TX_ISO_BIT]
    |=> !tx_dequeue) // R02
    else $error("packet released without ack");
  AST_ISO_COMPLETE: assert property (@(posedge clk) disable iff (!rst_i_n)
    state == ST_TX_WAIT && tx_done && sel[TX_ISO_BIT]
    |=> completion_push && completion_num == $past(cur_pkt)) // R01
    else $error("iso packet not completed");
  AST_DEQUEUE: assert property (@(posedge clk) disable iff (!rst_i_n)
    completion_push == tx_dequeue) // R03
    else $error("dequeue mismatch");
  AST_STALL_IN: assert property (@(posedge clk) disable iff (!rst_i_n)
    state == ST_IDLE && token_valid && addr_match
    && token_kind == 2'(TOK_IN) && tok_reg[5] == 1'b0 && tok_reg[3]
    |=> handshake == HS_STALL && handshake_valid) // R07
    else $error("stall not sent");
  AST_NAK_IN: assert property (@(posedge clk) disable iff (!rst_i_n)
    state == ST_IDLE && token_valid && addr_match
    && token_kind == 2'(TOK_IN) && tok_reg[5] && tok_reg[3]
    && !tok_reg[7] |=> handshake == HS_NAK && !send_data) // R08
    else $error("forced nak not sent");
  AST_RX_NORMAL: assert property (@(posedge clk) disable iff (!rst_i_n)
    rx_take && !sel[6] && sel[4] && !sel[2]
    |=> handshake == ($past(rx_ready) ? HS_ACK : HS_NAK)) // R10
    else $error("rx normal answer wrong");
  AST_UNEXPECTED_TOGGLE_FLAG: assert property (@(posedge clk) disable iff (!rst_i_n)
    rx_take |=> unexpected_toggle_flag
    == ($past(rx_data_toggle) == $past(sel[0]))) // R16
    else $error("unexpected toggle flag wrong");
  AST_RX_TOG: assert property (@(posedge clk) disable iff (!rst_i_n)
    rx_take |=> ep_reg[$past(cur_ep)][0] == $past(rx_data_toggle)) // R13
    else $error("rx toggle not recorded");
  AST_ALLOC: assert property (@(posedge clk) disable iff (!rst_i_n)
    state == ST_IDLE && token_valid && addr_match
    && token_kind != 2'(TOK_IN) |=> page_alloc_start) // R05
    else $error("page allocation not started");

  ////////////////////////////////////////////////////////////////////////
  // more checks: register port, token answers, release steps
  logic in_tok;
  // matched in token while idle
  assign in_tok = state == ST_IDLE && token_valid && addr_match
                  && token_kind == 2'(TOK_IN);

  // in token that will send data
  sequence s_in_data;
    in_tok && tx_send;
  endsequence
  // data packet launched and sequencer waiting
  sequence s_in_launched;
    send_data && state == ST_TX_WAIT;
  endsequence
  // packet popped and reported together
  sequence s_released;
    completion_push && tx_dequeue;
  endsequence

  AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_i_n)
    !rd_hit |=> reg_rdata == 8'h00) // R14
    else $error("read data not zero outside read");
  AST_RD_DATA: assert property (@(posedge clk) disable iff (!rst_i_n)
    rd_hit |=> reg_rdata == $past(ep_reg[wr_idx])) // R14
    else $error("read data wrong");
  AST_WR_FIELDS: assert property (@(posedge clk) disable iff (!rst_i_n)
    wr_hit |=> ep_reg[$past(wr_idx)][7:2] == $past(reg_wdata[7:2])) // R14
    else $error("control write not stored");
  AST_TX_OFF: assert property (@(posedge clk) disable iff (!rst_i_n)
    in_tok && !tok_reg[TX_HI_BIT] && !tok_reg[TX_LO_BIT]
    |=> !handshake_valid && !send_data) // R07
    else $error("disabled tx endpoint answered");
  AST_TX_DATA: assert property (@(posedge clk) disable iff (!rst_i_n)
    s_in_data |=> s_in_launched) // R08
    else $error("data packet not launched");
  AST_TX_EMPTY: assert property (@(posedge clk) disable iff (!rst_i_n)
    in_tok && tok_reg[TX_HI_BIT] && !tok_reg[TX_LO_BIT]
    && !tx_queue_has_data && !tok_reg[TX_ISO_BIT]
    |=> handshake == HS_NAK && handshake_valid && !send_data) // R08
    else $error("empty queue not answered with nak");
  AST_ACK_RELEASE: assert property (@(posedge clk) disable iff (!rst_i_n)
    state == ST_TX_WAIT && tx_done && host_ack |=> s_released) // R02
    else $error("acked packet not released");
  AST_NO_SPURIOUS_DEQ: assert property (@(posedge clk) disable iff (!rst_i_n)
    !tx_good |=> !tx_dequeue) // R03
    else $error("dequeue without good transmission");
  AST_RX_STALL: assert property (@(posedge clk) disable iff (!rst_i_n)
    rx_take && !sel[RX_ISO_BIT] && !sel[RX_HI_BIT] && sel[RX_LO_BIT]
    |=> handshake == HS_STALL && handshake_valid) // R09
    else $error("rx stall not sent");
  AST_RX_OFF: assert property (@(posedge clk) disable iff (!rst_i_n)
    rx_take && !sel[RX_HI_BIT] && !sel[RX_LO_BIT]
    |=> !handshake_valid) // R09
    else $error("disabled rx endpoint answered");
  AST_RX_NAK: assert property (@(posedge clk) disable iff (!rst_i_n)
    rx_take && !sel[RX_ISO_BIT] && sel[RX_HI_BIT] && sel[RX_LO_BIT]
    |=> handshake == HS_NAK && handshake_valid) // R10
    else $error("rx forced nak not sent");
  AST_TOKEN_IGNORED: assert property (@(posedge clk) disable iff (!rst_i_n)
    state != ST_IDLE && token_valid |=> !page_alloc_start) // R05
    else $error("token taken while busy");
endmodule : usb_endpoint_handshake_control

// ===== host_model.sv
// host side: issues tokens and ends data packets
`timescale 1ns/1ps
module host_model (
  input  wire logic  clk,
  output logic       token_valid,
  output logic [1:0] token_kind,
  output logic [3:0] token_ep,
  output logic       addr_match,
  output logic       rx_done,
  output logic       rx_data_toggle,
  output logic       tx_done,
  output logic       host_ack
);
  // idle lines at time zero
  initial begin
    {token_valid, token_kind, token_ep, addr_match} = '0;
    {rx_done, rx_data_toggle, tx_done, host_ack} = '0;
  end
  // one-cycle token, stale ep and match inverted afterwards, kind kept
  task automatic token(input logic [1:0] k, input logic [3:0] ep,
                       input logic m);
    @(posedge clk);
    token_valid <= 1'b1;
    token_kind  <= k;
    token_ep    <= ep;
    addr_match  <= m;
    @(posedge clk);
    token_valid <= 1'b0;
    token_ep    <= ~ep;
    addr_match  <= ~m;
  endtask : token
  // end of an out data packet after gap cycles
  task automatic rx_pkt(input logic t, input int gap);
    repeat (gap) @(posedge clk);
    rx_done        <= 1'b1;
    rx_data_toggle <= t;
    @(posedge clk);
    rx_done        <= 1'b0;
    rx_data_toggle <= ~t;
  endtask : rx_pkt
  // end of a sent packet, ack seen or not
  task automatic tx_end(input logic a, input int gap);
    repeat (gap) @(posedge clk);
    tx_done  <= 1'b1;
    host_ack <= a;
    @(posedge clk);
    tx_done  <= 1'b0;
    host_ack <= ~a;
  endtask : tx_end
endmodule : host_model

// ===== usb_endpoint_handshake_control_tb.sv
// self-checking bench for the endpoint handshake block
`timescale 1ns/1ps
module usb_endpoint_handshake_control_tb
  import endpoint_control_pkg::*;
;
  logic        clk, rst_n, reg_wr, reg_rd, rx_ready, qd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [3:0]  pnum, cnum, tep;
  logic [1:0]  hs, tkind;
  logic        hsv, sd, ttog, pas, utf, cpush, deq;
  logic        tv, am, rxd, rxt, txd, ack;
  int          errors, n_checks, n_push, n_deq, n_page;
  logic [3:0]  last_num;
  logic [2:0]  expq[$];
  logic [2:0]  got;
  logic [31:0] seed;

  usb_endpoint_handshake_control dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .token_valid(tv), .token_kind(tkind), .token_ep(tep),
    .addr_match(am), .rx_done(rxd), .rx_data_toggle(rxt),
    .rx_ready(rx_ready), .tx_done(txd), .host_ack(ack),
    .tx_queue_has_data(qd), .tx_packet_num(pnum), .handshake(hs),
    .handshake_valid(hsv), .send_data(sd), .tx_data_toggle(ttog),
    .page_alloc_start(pas), .unexpected_toggle_flag(utf),
    .completion_push(cpush), .completion_num(cnum), .tx_dequeue(deq)
  );
  host_model host (
    .clk(clk), .token_valid(tv), .token_kind(tkind), .token_ep(tep),
    .addr_match(am), .rx_done(rxd), .rx_data_toggle(rxt),
    .tx_done(txd), .host_ack(ack)
  );
  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] cfg(input logic ti, input logic ri,
                                     input logic [1:0] tc, rc);
    return {ti, ri, tc[1], rc[1], tc[0], rc[0], 2'h0};
  endfunction : cfg
  function automatic logic [15:0] ea(input int i);
    return ENDPOINT_CONTROL_BASE + 16'(i);
  endfunction : ea
  // expected answer per control code
  function automatic logic [2:0] ans(input logic [1:0] c, ok);
    case (c)
      CONT_OFF:    return 3'h0;
      CONT_STALL:  return {1'b0, HS_STALL};
      CONT_NORMAL: return {1'b0, ok};
      default:     return {1'b0, HS_NAK};
    endcase
  endfunction : ans
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : rdchk
  task automatic in_op(input logic [3:0] ep, input logic [2:0] e);
    if (e != 3'h0) expq.push_back(e);
    host.token(TOK_IN, ep, 1'b1);
    repeat (3) @(posedge clk);
  endtask : in_op
  task automatic out_op(input logic [1:0] k, input logic [3:0] ep,
                        input logic t, input logic [2:0] e);
    if (e != 3'h0) expq.push_back(e);
    host.token(k, ep, 1'b1);
    host.rx_pkt(t, 2);
    repeat (3) @(posedge clk);
  endtask : out_op
  ////////////////////////////////////////////////////////////////////////
  // oldest note taken whenever an answer appears; pulses counted
  always @(posedge clk) begin
    if (sd === 1'b1 || (hsv === 1'b1 && hs !== HS_NONE)) begin
      got = (sd === 1'b1) ? 3'h4 : {1'b0, hs};
      if (expq.size() == 0) check({5'h0, got}, 8'hff);
      else check({5'h0, got}, {5'h0, expq.pop_front()});
    end
    if (cpush === 1'b1) begin
      n_push++;
      last_num = cnum;
    end
    if (deq === 1'b1) n_deq++;
    if (pas === 1'b1) n_page++;
  end
  // hang guard
  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
  // reset, registers, in traffic, out traffic
  initial begin
    rst_n = 1'b0;
    {reg_wr, reg_rd, rx_ready, qd, reg_addr, reg_wdata, pnum} = '0;
    seed = 32'h545d;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < NUM_EP; i++) begin
      seed = lfsr(seed);
      rdchk(ea(i), ENDPOINT_CONTROL_RESET);
      wr(ea(i), seed[7:0]);
      rdchk(ea(i), seed[7:0] & EP_WR_MASK);
    end
    wr(ENDPOINT_CONTROL_LAST + 16'h1, 8'hff);
    rdchk(ENDPOINT_CONTROL_LAST + 16'h1, 8'h00);
    wr(ea(3), 8'h00);
    qd <= 1'b1;
    for (int c = 0; c < 4; c++) if (c != 2) begin
      wr(ea(3), cfg(1'b0, 1'b0, 2'(c), 2'h0));
      in_op(4'h3, ans(2'(c), HS_NAK));
    end
    wr(ea(3), cfg(1'b0, 1'b0, CONT_NORMAL, 2'h0));
    qd <= 1'b0;
    in_op(4'h3, {1'b0, HS_NAK});
    qd <= 1'b1;
    pnum <= seed[11:8];
    in_op(4'h3, 3'h4);
    host.tx_end(1'b0, 2);
    repeat (3) @(posedge clk);
    check(8'(n_push), 8'h00);
    in_op(4'h3, 3'h4);
    host.tx_end(1'b1, 6);
    repeat (3) @(posedge clk);
    check(8'(n_deq), 8'h01);
    check({4'h0, last_num}, {4'h0, seed[11:8]});
    check({7'h0, ttog}, 8'h01);
    wr(ea(3), cfg(1'b1, 1'b0, CONT_NORMAL, 2'h0) | 8'h02);
    pnum <= seed[15:12];
    in_op(4'h3, 3'h4);
    host.tx_end(1'b0, 2);
    repeat (3) @(posedge clk);
    check(8'(n_push), 8'h02);
    check({4'h0, last_num}, {4'h0, seed[15:12]});
    rdchk(ea(3), cfg(1'b1, 1'b0, CONT_NORMAL, 2'h0));
    rx_ready <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(ea(5), cfg(1'b0, 1'b0, 2'h0, 2'(c)));
      seed = lfsr(seed);
      out_op(TOK_OUT, 4'h5, seed[0], ans(2'(c), HS_ACK));
    end
    wr(ea(5), cfg(1'b0, 1'b0, 2'h0, CONT_NORMAL));
    rx_ready <= 1'b0;
    out_op(TOK_OUT, 4'h5, seed[1], {1'b0, HS_NAK});
    rx_ready <= 1'b1;
    out_op(TOK_SETUP, 4'h5, seed[2], {1'b0, HS_ACK});
    wr(ea(5), cfg(1'b0, 1'b1, 2'h0, CONT_NORMAL));
    out_op(TOK_OUT, 4'h5, seed[3], 3'h0);
    out_op(TOK_SETUP, 4'h5, seed[4], 3'h0);
    host.token(TOK_OUT, 4'h5, 1'b0);
    repeat (3) @(posedge clk);
    check(8'(n_page), 8'h08);
    wr(ea(6), cfg(1'b0, 1'b0, 2'h0, CONT_NORMAL));
    for (int k = 0; k < 3; k++) begin
      out_op(TOK_OUT, 4'h6, k != 0, {1'b0, HS_ACK});
      check({7'h0, utf}, {7'h0, k != 1});
      rdchk(ea(6), cfg(1'b0, 1'b0, 2'h0, CONT_NORMAL) | 8'(k != 0));
    end
    check(8'(expq.size()), 8'h00);
    report_and_stop();
  end
endmodule : usb_endpoint_handshake_control_tb
